//--- hdl/cbs_pkg.sv
// Shared constants, types and state layout for the CPU bus cycle sequencer.
package cbs_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int INTERVAL_NS   = 75;
  localparam int SVC_OFF_NS    = 8625;
  localparam int SVC_ON_NS     = 9750;
  localparam int LATENCY_NS    = 12600;
  localparam int INTERVAL_CYC  = (INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SVC_OFF_CYC   = (SVC_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SVC_ON_CYC    = (SVC_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATENCY_CYC   = LATENCY_NS / CLK_PERIOD_NS;

  localparam logic [1:0] TICK_LAST = 2'(INTERVAL_CYC - 1);
  localparam logic [9:0] SVC_OFF_T = 10'(SVC_OFF_CYC);
  localparam logic [9:0] SVC_ON_T  = 10'(SVC_ON_CYC);
  localparam logic [9:0] LAT_T     = 10'(LATENCY_CYC);
  localparam logic [9:0] CNT_MAX   = 10'h3FF;

  // ---------------------------------------------------------------------
  // Registers and status word
  // ---------------------------------------------------------------------
  localparam int         NUM_GPR     = 9;
  localparam logic [2:0] SP_IDX      = 3'h6;
  localparam logic [2:0] PC_IDX      = 3'h7;
  localparam logic [3:0] USER_SP_IDX = 4'h8;
  localparam int         PSW_CUR_LO  = 14;
  localparam int         PSW_PRV_LO  = 12;
  localparam int         PSW_PRI_LO  = 5;
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [1:0] MODE_USER   = 2'h3;
  localparam logic [15:0] RESET_PC   = 16'h0000;
  localparam logic [15:0] WORD_STEP  = 16'h0002;
  localparam logic [21:0] ADDR18_MASK = 22'h03_FFFF;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    NO_BUS_CYCLE, WORD_READ_CYCLE, WORD_WRITE_CYCLE, BYTE_WRITE_CYCLE,
    WORD_READ_MODIFY_WRITE_CYCLE, BYTE_READ_MODIFY_WRITE_CYCLE
  } cbs_cyc_e;

  typedef enum logic [1:0] {SP_NONE, SP_PUSH, SP_POP} cbs_spop_e;

  typedef enum logic [8:0] {
    ST_BOUNDARY = 9'h001, ST_ADDR = 9'h002, ST_DIN = 9'h004,
    ST_MODIFY = 9'h008, ST_DOUT = 9'h010, ST_TAIL = 9'h020,
    ST_EXEC = 9'h040, ST_DMA = 9'h080, ST_SERVICE = 9'h100
  } cbs_state_e;

  typedef enum logic [2:0] {
    CTX_FETCH, CTX_OP, CTX_VECTOR, CTX_PUSH_PS, CTX_PUSH_PC, CTX_LOAD_PC, CTX_LOAD_PS
  } cbs_ctx_e;

  typedef struct packed {
    cbs_cyc_e    cyc;
    logic [21:0] addr;
    logic [15:0] wdata;
    cbs_spop_e   sp;
    logic        last;
  } cbs_op_s;

  typedef struct packed {
    logic        sync;
    logic        din;
    logic        dout;
    logic        wtbt;
    logic        iack;
    logic        dma_grant;
    logic [21:0] dal;
    logic        dal_oe_n;
  } cbs_bus_s;

  typedef struct packed {
    cbs_state_e        st;
    cbs_state_e        ret;
    cbs_ctx_e          ctx;
    logic [1:0]        tick_cnt;
    logic [8:0][15:0]  gpr;
    logic [15:0]       psw;
    cbs_cyc_e          cyc;
    logic [21:0]       addr;
    logic [15:0]       wdata;
    logic [15:0]       rdata;
    logic [15:0]       vec;
    logic              last;
    cbs_spop_e         spop;
    logic [6:0]        s1;
    logic [6:0]        s2;
    logic [15:0]       d1;
    logic [15:0]       d2;
    logic              ext_bp;
    logic [1:0]        strap_cnt;
    logic              in_svc;
    logic [9:0]        svc_cnt;
    logic [9:0]        lat_cnt;
    logic              lat_over;
    cbs_bus_s          bus;
    logic [15:0]       instr;
    logic              instr_valid;
    logic              op_done;
    logic              rmw_read;
    logic [15:0]       rf_rdata;
  } cbs_state_s;

endpackage : cbs_pkg

//--- hdl/cbs_sequencer.sv
// Register file and backplane bus cycle sequencer of the processor.
`timescale 1ns/100ps
module cbs_sequencer
  import cbs_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Configuration.
  input  wire logic        ext_backplane_i,
  input  wire logic        mmu_en_i,
  // Operation request from the execution logic.
  input  wire logic        op_valid_i,
  output logic             op_ready_o,
  input  wire cbs_op_s     op_i,
  output logic             op_done_o,
  output logic [15:0]      op_rdata_o,
  output logic             rmw_read_o,
  input  wire logic        mod_valid_i,
  input  wire logic [15:0] mod_wdata_i,
  // Fetched instruction.
  output logic             instr_valid_o,
  output logic [15:0]      instr_o,
  // Register file and status word access.
  input  wire logic        rf_we_i,
  input  wire logic [2:0]  rf_idx_i,
  input  wire logic [15:0] rf_wdata_i,
  input  wire logic [2:0]  rf_ridx_i,
  output logic [15:0]      rf_rdata_o,
  input  wire logic        psw_we_i,
  input  wire logic [15:0] psw_wdata_i,
  output logic [15:0]      processor_status_word_o,
  output logic [15:0]      program_counter_reg_o,
  output logic [15:0]      stack_pointer_reg_o,
  output logic             latency_over_o,
  // Backplane bus.
  input  wire logic [15:0] shared_addr_data_lines_i,
  output logic [21:0]      shared_addr_data_lines_o,
  output logic             shared_addr_data_lines_oe_n_o,
  output logic             bus_sync_o,
  output logic             bus_din_o,
  output logic             bus_dout_o,
  output logic             bus_wtbt_o,
  input  wire logic        bus_rply_i,
  input  wire logic        dma_req_i,
  output logic             dma_grant_o,
  input  wire logic [3:0]  irq_i,
  output logic             iack_o
);

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------
  function automatic logic [3:0] phys_idx(logic [2:0] idx, logic [1:0] mode);
    phys_idx = (idx == SP_IDX && mode == MODE_USER) ? USER_SP_IDX : {1'b0, idx};
  endfunction : phys_idx

  function automatic logic [1:0] coerce_mode(logic [1:0] m);
    coerce_mode = (m == MODE_KERNEL) ? MODE_KERNEL : MODE_USER;
  endfunction : coerce_mode

  function automatic logic [15:0] coerce_psw(logic [15:0] p);
    coerce_psw = {coerce_mode(p[15:14]), coerce_mode(p[13:12]), p[11:0]};
  endfunction : coerce_psw

  // Level 0 means no request; bits 3..0 carry levels 7..4.
  function automatic logic [2:0] irq_level(logic [3:0] r);
    if (r[3]) begin
      irq_level = 3'h7;
    end else if (r[2]) begin
      irq_level = 3'h6;
    end else if (r[1]) begin
      irq_level = 3'h5;
    end else if (r[0]) begin
      irq_level = 3'h4;
    end else begin
      irq_level = 3'h0;
    end
  endfunction : irq_level

  function automatic logic is_read_class(cbs_cyc_e c);
    is_read_class = (c == WORD_READ_CYCLE) || (c == WORD_READ_MODIFY_WRITE_CYCLE)
                 || (c == BYTE_READ_MODIFY_WRITE_CYCLE);
  endfunction : is_read_class

  function automatic logic is_byte(cbs_cyc_e c);
    is_byte = (c == BYTE_WRITE_CYCLE) || (c == BYTE_READ_MODIFY_WRITE_CYCLE);
  endfunction : is_byte

  function automatic logic [21:0] phys_addr(logic [21:0] a, logic mmu, logic ext, cbs_cyc_e c);
    logic [21:0] p;
    p = mmu ? a : {6'h00, a[15:0]};
    if (!ext) begin
      p = p & ADDR18_MASK;
    end
    if (!is_byte(c)) begin
      p[0] = 1'b0;
    end
    phys_addr = p;
  endfunction : phys_addr

  // Places a byte on the lane that the address selects; words pass whole.
  function automatic logic [15:0] out_data(logic [15:0] d, cbs_cyc_e c, logic a0);
    if (!is_byte(c)) begin
      out_data = d;
    end else if (a0) begin
      out_data = {d[7:0], 8'h00};
    end else begin
      out_data = {8'h00, d[7:0]};
    end
  endfunction : out_data

  // Opens a bus cycle with the address on the shared lines.
  function automatic cbs_state_s start_cycle(cbs_state_s s, cbs_ctx_e ctx, cbs_cyc_e c,
                                             logic [21:0] a, logic [15:0] d);
    cbs_state_s t;
    t              = s;
    t.ctx          = ctx;
    t.cyc          = c;
    t.addr         = a;
    t.wdata        = d;
    t.st           = ST_ADDR;
    t.bus.dal      = a;
    t.bus.dal_oe_n = 1'b0;
    t.bus.sync     = 1'b0;
    t.bus.wtbt     = !is_read_class(c);
    start_cycle    = t;
  endfunction : start_cycle

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  cbs_state_s  state_reg;
  cbs_state_s  state_next;
  logic        tick;
  logic        rply_s;
  logic        dreq_s;
  logic [2:0]  lvl;
  logic        take;
  logic [1:0]  cur_mode;
  logic [3:0]  sp_vis;
  logic [15:0] ksp_dec;
  logic [9:0]  svc_target;

  assign tick       = (state_reg.tick_cnt == TICK_LAST);
  assign rply_s     = state_reg.s2[0];
  assign dreq_s     = state_reg.s2[1];
  assign lvl        = irq_level(state_reg.s2[5:2]);
  assign take       = lvl > state_reg.psw[PSW_PRI_LO +: 3];
  assign cur_mode   = state_reg.psw[PSW_CUR_LO +: 2];
  assign sp_vis     = phys_idx(SP_IDX, cur_mode);
  assign ksp_dec    = state_reg.gpr[SP_IDX] - WORD_STEP;
  assign svc_target = mmu_en_i ? SVC_ON_T : SVC_OFF_T;

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    state_next             = state_reg;
    state_next.s1          = {ext_backplane_i, irq_i, dma_req_i, bus_rply_i};
    state_next.s2          = state_reg.s1;
    state_next.d1          = shared_addr_data_lines_i;
    state_next.d2          = state_reg.d1;
    state_next.tick_cnt    = tick ? 2'h0 : state_reg.tick_cnt + 2'h1;
    state_next.instr_valid = 1'b0;
    state_next.op_done     = 1'b0;
    state_next.rmw_read    = 1'b0;

    // The strap is caught once, after the synchroniser has filled.
    if (state_reg.strap_cnt != 2'h3) begin
      state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
      if (state_reg.strap_cnt == 2'h2) begin
        state_next.ext_bp = state_reg.s2[6];
      end
    end

    // Register and status writes from execution cost no bus cycle.
    if (psw_we_i) begin
      state_next.psw = coerce_psw(psw_wdata_i);
    end
    if (rf_we_i) begin
      state_next.gpr[phys_idx(rf_idx_i, cur_mode)] = rf_wdata_i;
    end
    state_next.rf_rdata = state_reg.gpr[phys_idx(rf_ridx_i, cur_mode)];

    if (state_reg.in_svc && state_reg.svc_cnt != CNT_MAX) begin
      state_next.svc_cnt = state_reg.svc_cnt + 10'h001;
    end
    if (take && !state_reg.in_svc) begin
      state_next.lat_cnt = (state_reg.lat_cnt == CNT_MAX) ? CNT_MAX : state_reg.lat_cnt + 10'h001;
    end else begin
      state_next.lat_cnt = 10'h000;
    end
    state_next.lat_over = state_reg.lat_cnt >= LAT_T;

    case (state_reg.st)
      ST_BOUNDARY: begin
        if (dreq_s) begin
          state_next.ret           = ST_BOUNDARY;
          state_next.st            = ST_DMA;
          state_next.bus.dma_grant = 1'b1;
        end else if (take) begin
          state_next.ctx     = CTX_VECTOR;
          state_next.cyc     = WORD_READ_CYCLE;
          state_next.bus.iack = 1'b1;
          state_next.bus.din = 1'b1;
          state_next.st      = ST_DIN;
          state_next.in_svc  = 1'b1;
          state_next.svc_cnt = 10'h000;
        end else begin
          state_next = start_cycle(state_next, CTX_FETCH, WORD_READ_CYCLE,
                                   {6'h00, state_reg.gpr[PC_IDX]}, 16'h0000);
        end
      end

      ST_ADDR: begin
        if (tick) begin
          if (!state_reg.bus.sync) begin
            state_next.bus.sync = 1'b1;
          end else if (is_read_class(state_reg.cyc)) begin
            state_next.bus.wtbt     = 1'b0;
            state_next.bus.dal_oe_n = 1'b1;
            state_next.bus.din      = 1'b1;
            state_next.st           = ST_DIN;
          end else begin
            state_next.bus.dal  = {6'h00, out_data(state_reg.wdata, state_reg.cyc, state_reg.addr[0])};
            state_next.bus.wtbt = is_byte(state_reg.cyc);
            state_next.bus.dout = 1'b1;
            state_next.st       = ST_DOUT;
          end
        end
      end

      ST_DIN: begin
        if (rply_s) begin
          state_next.rdata    = state_reg.d2;
          state_next.bus.din  = 1'b0;
          state_next.bus.iack = 1'b0;
          if (state_reg.cyc == WORD_READ_MODIFY_WRITE_CYCLE
              || state_reg.cyc == BYTE_READ_MODIFY_WRITE_CYCLE) begin
            state_next.rmw_read = 1'b1;
            state_next.st       = ST_MODIFY;
          end else begin
            state_next.st = ST_TAIL;
          end
        end
      end

      // The bus stays held here, so no DMA grant can slip in.
      ST_MODIFY: begin
        if (mod_valid_i && !rply_s) begin
          state_next.bus.dal      = {6'h00, out_data(mod_wdata_i, state_reg.cyc, state_reg.addr[0])};
          state_next.bus.dal_oe_n = 1'b0;
          state_next.bus.wtbt     = is_byte(state_reg.cyc);
          state_next.bus.dout     = 1'b1;
          state_next.st           = ST_DOUT;
        end
      end

      ST_DOUT: begin
        if (rply_s) begin
          state_next.bus.dout     = 1'b0;
          state_next.bus.wtbt     = 1'b0;
          state_next.bus.dal_oe_n = 1'b1;
          state_next.st           = ST_TAIL;
        end
      end

      ST_TAIL: begin
        if (!rply_s && tick) begin
          state_next.bus.sync = 1'b0;
          case (state_reg.ctx)
            CTX_FETCH: begin
              state_next.instr          = state_reg.rdata;
              state_next.instr_valid    = 1'b1;
              state_next.gpr[PC_IDX]    = state_reg.gpr[PC_IDX] + WORD_STEP;
              state_next.st             = ST_EXEC;
            end
            CTX_OP: begin
              state_next.op_done = 1'b1;
              if (state_reg.spop == SP_POP) begin
                state_next.gpr[sp_vis] = state_reg.gpr[sp_vis] + WORD_STEP;
              end
              state_next.st = state_reg.last ? ST_BOUNDARY : ST_EXEC;
            end
            CTX_VECTOR: begin
              state_next.vec         = state_reg.rdata;
              state_next.gpr[SP_IDX] = ksp_dec;
              state_next = start_cycle(state_next, CTX_PUSH_PS, WORD_WRITE_CYCLE,
                                       {6'h00, ksp_dec}, state_reg.psw);
            end
            CTX_PUSH_PS: begin
              state_next.gpr[SP_IDX] = ksp_dec;
              state_next = start_cycle(state_next, CTX_PUSH_PC, WORD_WRITE_CYCLE,
                                       {6'h00, ksp_dec}, state_reg.gpr[PC_IDX]);
            end
            CTX_PUSH_PC: begin
              state_next = start_cycle(state_next, CTX_LOAD_PC, WORD_READ_CYCLE,
                                       {6'h00, state_reg.vec}, 16'h0000);
            end
            CTX_LOAD_PC: begin
              state_next.gpr[PC_IDX] = state_reg.rdata;
              state_next = start_cycle(state_next, CTX_LOAD_PS, WORD_READ_CYCLE,
                                       {6'h00, state_reg.vec + WORD_STEP}, 16'h0000);
            end
            CTX_LOAD_PS: begin
              state_next.psw = {coerce_mode(state_reg.rdata[15:14]), cur_mode,
                                state_reg.rdata[11:0]};
              state_next.st  = ST_SERVICE;
            end
            default: begin
              state_next.st = ST_BOUNDARY;
            end
          endcase
        end
      end

      ST_EXEC: begin
        if (dreq_s) begin
          state_next.ret           = ST_EXEC;
          state_next.st            = ST_DMA;
          state_next.bus.dma_grant = 1'b1;
        end else if (op_valid_i) begin
          if (op_i.cyc == NO_BUS_CYCLE) begin
            state_next.op_done = 1'b1;
            state_next.st      = op_i.last ? ST_BOUNDARY : ST_EXEC;
          end else begin
            state_next.last = op_i.last;
            state_next.spop = op_i.sp;
            if (op_i.sp == SP_PUSH) begin
              state_next.gpr[sp_vis] = state_reg.gpr[sp_vis] - WORD_STEP;
              state_next = start_cycle(state_next, CTX_OP, op_i.cyc,
                                       {6'h00, state_reg.gpr[sp_vis] - WORD_STEP}, op_i.wdata);
            end else if (op_i.sp == SP_POP) begin
              state_next = start_cycle(state_next, CTX_OP, op_i.cyc,
                                       {6'h00, state_reg.gpr[sp_vis]}, op_i.wdata);
            end else begin
              state_next = start_cycle(state_next, CTX_OP, op_i.cyc,
                                       phys_addr(op_i.addr, mmu_en_i, state_reg.ext_bp, op_i.cyc),
                                       op_i.wdata);
            end
          end
        end
      end

      ST_DMA: begin
        if (!dreq_s) begin
          state_next.bus.dma_grant = 1'b0;
          state_next.st            = state_reg.ret;
        end
      end

      ST_SERVICE: begin
        if (state_reg.svc_cnt >= svc_target) begin
          state_next.in_svc = 1'b0;
          state_next.st     = ST_BOUNDARY;
        end
      end

      default: begin
        state_next.st = ST_BOUNDARY;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg              <= '0;
      state_reg.st           <= ST_BOUNDARY;
      state_reg.ret          <= ST_BOUNDARY;
      state_reg.gpr[PC_IDX]  <= RESET_PC;
      state_reg.bus.dal_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign op_ready_o                    = (state_reg.st == ST_EXEC) && !dreq_s;
  assign op_done_o                     = state_reg.op_done;
  assign op_rdata_o                    = state_reg.rdata;
  assign rmw_read_o                    = state_reg.rmw_read;
  assign instr_valid_o                 = state_reg.instr_valid;
  assign instr_o                       = state_reg.instr;
  assign rf_rdata_o                    = state_reg.rf_rdata;
  assign processor_status_word_o       = state_reg.psw;
  assign program_counter_reg_o         = state_reg.gpr[PC_IDX];
  assign stack_pointer_reg_o           = state_reg.gpr[sp_vis];
  assign latency_over_o                = state_reg.lat_over;
  assign shared_addr_data_lines_o      = state_reg.bus.dal;
  assign shared_addr_data_lines_oe_n_o = state_reg.bus.dal_oe_n;
  assign bus_sync_o                    = state_reg.bus.sync;
  assign bus_din_o                     = state_reg.bus.din;
  assign bus_dout_o                    = state_reg.bus.dout;
  assign bus_wtbt_o                    = state_reg.bus.wtbt;
  assign dma_grant_o                   = state_reg.bus.dma_grant;
  assign iack_o                        = state_reg.bus.iack;

endmodule : cbs_sequencer

//--- tb/cbs_seq_monitor.sv
// Concurrent checks on the sequencer's bus and handshake ports.
`timescale 1ns/100ps
module cbs_seq_monitor (
  input wire logic clk_i, rstn_i, bus_sync_o, bus_din_o, bus_dout_o, iack_o,
  input wire logic dma_grant_o, op_ready_o, op_done_o, rmw_read_o, instr_valid_o, op_valid_i,
  input wire logic shared_addr_data_lines_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_grant_off_bus: assert property (dma_grant_o |-> !bus_sync_o) else $error("grant in cycle");
  a_ready_no_bus: assert property (op_ready_o |-> !bus_sync_o && !dma_grant_o) else $error("ready busy");
  a_dir_exclusive: assert property (!(bus_din_o && bus_dout_o)) else $error("din with dout");
  a_addr_at_sync: assert property ($rose(bus_sync_o) |-> !shared_addr_data_lines_oe_n_o) else $error("no addr");
  a_read_release: assert property (bus_din_o |-> shared_addr_data_lines_oe_n_o) else $error("lines held");
  a_write_drive: assert property (bus_dout_o |-> !shared_addr_data_lines_oe_n_o) else $error("no data");
  a_fetch_ends: assert property (instr_valid_o |-> $fell(bus_sync_o)) else $error("fetch end");
  a_rmw_held: assert property (rmw_read_o |-> bus_sync_o ##1 bus_sync_o) else $error("rmw split");
  a_iack_no_sync: assert property (iack_o |-> !bus_sync_o) else $error("iack in cycle");
  a_done_pulse: assert property (op_done_o && !op_valid_i |=> !op_done_o) else $error("done held");
  c_rmw: cover property (rmw_read_o);
  c_dma: cover property (dma_grant_o);
  c_fetch: cover property (instr_valid_o);
  c_iack: cover property (iack_o);
endmodule : cbs_seq_monitor
bind cbs_sequencer cbs_seq_monitor u_mon (.*);

//--- tb/cbs_slave_model.sv
// Memory slave on the multiplexed backplane bus.
`timescale 1ns/100ps
module cbs_slave_model (
  input  wire logic        clk_i, sync_i, din_i, dout_i, wtbt_i,
  input  wire logic [21:0] dal_i,
  output logic [15:0]      dal_o,
  output logic             rply_o
);
  logic [15:0] m [int];
  logic [15:0] a, rd;
  logic        sq;
  initial begin rply_o = 0; sq = 0; rd = 0; a = 0; end
  // Released lines show the inverse of the last value.
  assign dal_o = (rply_o && din_i) ? rd : ~rd;
  always @(posedge clk_i) begin
    sq <= sync_i;
    if (sync_i && !sq) a <= dal_i[15:0];
    if (din_i) begin
      rd <= m.exists(a >> 1) ? m[a >> 1] : ({a[15:1], 1'b0} ^ 16'hA5A5);
      rply_o <= 1;
    end else if (dout_i && !rply_o) begin
      if (!m.exists(a >> 1)) m[a >> 1] = {a[15:1], 1'b0} ^ 16'hA5A5;
      if (!wtbt_i) m[a >> 1] = dal_i[15:0];
      else if (a[0]) m[a >> 1][15:8] = dal_i[15:8];
      else m[a >> 1][7:0] = dal_i[7:0];
      rply_o <= 1;
    end else if (!dout_i) rply_o <= 0;
  end
endmodule : cbs_slave_model

//--- tb/cpu_bus_cycle_sequencer_tb_top.sv
// Self-checking bench for the CPU bus cycle sequencer.
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; $display("wrong value %s exp %h got %h", n, e, s); end end
module cpu_bus_cycle_sequencer_tb_top;
  import cbs_pkg::*;
  logic clk_i = 0, rstn_i = 0, opv = 0, done, rdy, rmw, iv, rwe = 0, dreq = 0, gnt, sync, din, dout, wtbt, oen, rply;
  logic [15:0] rdat, instr, rfr, dali, w, m [int];
  logic [21:0] dalo;
  logic [2:0] ridx = 0;
  logic [15:0] wd = 0, mw = 0, pcv, spv, psv, v;
  logic [3:0] irq = 0;
  logic lato, ack;
  cbs_spop_e spo = SP_NONE;
  cbs_op_s op = '0;
  int err_total = 0, checks = 0, seed = 64409, k, i;
  logic [15:0] a;
  always #12.5 clk_i = ~clk_i;
  cbs_sequencer DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ext_backplane_i(1'b0), .mmu_en_i(1'b0), .op_valid_i(opv),
    .op_ready_o(rdy), .op_i(op), .op_done_o(done), .op_rdata_o(rdat), .rmw_read_o(rmw), .mod_valid_i(1'b1),
    .mod_wdata_i(mw), .instr_valid_o(iv), .instr_o(instr), .rf_we_i(rwe), .rf_idx_i(ridx), .rf_wdata_i(wd),
    .rf_ridx_i(ridx), .rf_rdata_o(rfr), .psw_we_i(1'b0), .psw_wdata_i(wd), .processor_status_word_o(psv),
    .program_counter_reg_o(pcv), .stack_pointer_reg_o(spv), .latency_over_o(lato), .shared_addr_data_lines_i(dali),
    .shared_addr_data_lines_o(dalo), .shared_addr_data_lines_oe_n_o(oen), .bus_sync_o(sync), .bus_din_o(din),
    .bus_dout_o(dout), .bus_wtbt_o(wtbt), .bus_rply_i(rply), .dma_req_i(dreq), .dma_grant_o(gnt),
    .irq_i(irq), .iack_o(ack));
  cbs_slave_model u_mem (.clk_i(clk_i), .sync_i(sync), .din_i(din), .dout_i(dout), .wtbt_i(wtbt),
    .dal_i(dalo), .dal_o(dali), .rply_o(rply));
  function automatic logic [15:0] ex(input logic [15:0] x);
    return m.exists(x >> 1) ? m[x >> 1] : ({x[15:1], 1'b0} ^ 16'hA5A5);
  endfunction : ex
  task automatic op_run(input cbs_cyc_e c, input logic [15:0] ad, input logic [15:0] dw, input logic l);
    op = '{c, {6'h00, ad}, dw, spo, l};
    opv = 1;
    for (k = 0; k < 999 && rdy !== 1; k++) @(negedge clk_i);
    @(posedge clk_i);
    #2 opv = 0;
    for (k = 0; k < 999 && done !== 1; k++) @(negedge clk_i);
    if (k >= 999) err_total++;
    if (c == NO_BUS_CYCLE) `CHK("nobus lines", 1'b1, oen)
    @(posedge clk_i);
    #2;
  endtask : op_run
  task automatic wait_iv(input logic [15:0] pc);
    for (k = 0; k < 999 && iv !== 1; k++) @(negedge clk_i);
    if (k >= 999) err_total++;
    `CHK("instr", ex(pc), instr)
  endtask : wait_iv
  task conclude;
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  initial begin
    #2_000_000 err_total++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    #2 rstn_i = 1;
    wait_iv(16'h0000);
    `CHK("pc", RESET_PC + WORD_STEP, pcv)
    `CHK("psw", 16'h0000, psv)
    @(posedge clk_i);
    #2 dreq = 1;
    for (k = 0; k < 99 && gnt !== 1; k++) @(negedge clk_i);
    `CHK("grant", 1'b1, gnt)
    @(posedge clk_i);
    #2 dreq = 0;
    ridx = 3'h3;
    wd = 16'($random(seed));
    rwe = 1;
    @(posedge clk_i);
    #2 rwe = 0;
    repeat (2) @(posedge clk_i);
    #2;
    `CHK("reg", wd, rfr)
    spo = SP_PUSH;
    w = 16'($random(seed));
    op_run(WORD_WRITE_CYCLE, 16'h0000, w, 0);
    m[16'hFFFE >> 1] = w;
    `CHK("sp push", 16'hFFFE, spv)
    spo = SP_POP;
    op_run(WORD_READ_CYCLE, 16'h0000, 16'h0000, 0);
    spo = SP_NONE;
    `CHK("pop", w, rdat)
    `CHK("sp pop", 16'h0000, spv)
    for (i = 0; i < 4; i++) begin
      if (i == 3) irq = 4'h8;
      a = 16'($random(seed)) & 16'hFFFE;
      w = 16'($random(seed));
      op_run(WORD_WRITE_CYCLE, a, w, 0);
      m[a >> 1] = w;
      w = 16'($random(seed));
      op_run(BYTE_WRITE_CYCLE, a | 16'h0001, w, 0);
      m[a >> 1][15:8] = w[7:0];
      op_run(WORD_READ_CYCLE, a, 16'h0000, 0);
      `CHK("read", ex(a), rdat)
      mw = 16'($random(seed));
      op_run(WORD_READ_MODIFY_WRITE_CYCLE, a, 16'h0000, 0);
      `CHK("rmw", ex(a), rdat)
      m[a >> 1] = mw;
      op_run(WORD_READ_CYCLE, a, 16'h0000, 0);
      `CHK("rmw wr", ex(a), rdat)
      mw = 16'($random(seed));
      op_run(BYTE_READ_MODIFY_WRITE_CYCLE, a, 16'h0000, 0);
      `CHK("rmwb", ex(a), rdat)
      m[a >> 1][7:0] = mw[7:0];
      op_run(WORD_READ_CYCLE, a, 16'h0000, 0);
      `CHK("rmwb wr", ex(a), rdat)
      op_run(NO_BUS_CYCLE, 16'h0000, 16'h0000, i == 3);
      `CHK("nobus", 1'b0, sync)
    end
    for (k = 0; k < 999 && ack !== 1; k++) @(negedge clk_i);
    `CHK("iack", 1'b1, ack)
    `CHK("latency", 1'b0, lato)
    v = ex(a);
    @(posedge clk_i);
    #2 irq = 4'h0;
    m[16'hFFFE >> 1] = 16'h0000;
    m[16'hFFFC >> 1] = RESET_PC + WORD_STEP;
    w = ex(v + WORD_STEP);
    wait_iv(ex(v));
    `CHK("svc", 1'b1, k >= SVC_OFF_CYC)
    `CHK("pc", ex(v) + WORD_STEP, pcv)
    `CHK("psw", {(w[15:14] == MODE_KERNEL) ? MODE_KERNEL : MODE_USER, MODE_KERNEL, w[11:0]}, psv)
    conclude();
  end
endmodule : cpu_bus_cycle_sequencer_tb_top
